//--- inc/tcs_pkg.sv
package tcs_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 16;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [23:0] OFS_RUN   = 24'hFFFEB0;
    localparam logic [23:0] OFS_LOCK  = 24'hFFFEB1;
    localparam logic [23:0] OFS_CTRL  = 24'hFFFF10;
    localparam logic [23:0] OFS_MODE  = 24'hFFFF11;
    localparam logic [23:0] OFS_IOCTL = 24'hFFFF12;
    localparam logic [23:0] OFS_IRQEN = 24'hFFFF14;
    localparam logic [23:0] OFS_STAT  = 24'hFFFF15;
    localparam logic [23:0] OFS_CNT   = 24'hFFFF16;
    localparam logic [23:0] OFS_GRA   = 24'hFFFF18;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned BIT_DIR   = 7;
    localparam int unsigned BIT_UNF   = 5;
    localparam int unsigned BIT_OVF   = 4;
    localparam int unsigned BIT_MCA   = 0;
    localparam int unsigned BIT_DOWN  = 0;
    localparam int unsigned CCLR_LSB  = 5;
    localparam int unsigned CKEG_LSB  = 3;
    localparam int unsigned TPSC_LSB  = 0;
    localparam int unsigned IOA_LSB   = 0;
    localparam int unsigned IOB_LSB   = 4;
    localparam int unsigned CH_COUNT  = 3;

    // ----------------------------------------------------------------
    // field codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CCLR_ON_A     = 3'h1;
    localparam logic [3:0] IOA_CAPT_RISE = 4'h8;

    // ----------------------------------------------------------------
    // prescaler masks, internal clock divided by 1, 4, 16, 64
    // ----------------------------------------------------------------
    localparam int unsigned PSC_W     = 6;
    localparam logic [5:0] PSC_MASK_1  = 6'h00;
    localparam logic [5:0] PSC_MASK_4  = 6'h03;
    localparam logic [5:0] PSC_MASK_16 = 6'h0F;
    localparam logic [5:0] PSC_MASK_64 = 6'h3F;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_CNT  = 16'h0000;
    localparam logic [15:0] RST_GRA  = 16'h0000;
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RD_NONE  = 16'h0000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tcs_bus_req_s;

    typedef struct packed {
        logic unf;
        logic ovf;
        logic mca;
        logic any;
    } tcs_irq_s;

    typedef struct packed {
        logic [2:0]  run;
        logic [2:0]  lock;
        logic [2:0]  cclr;
        logic [1:0]  ckeg;
        logic [2:0]  tpsc;
        logic        down;
        logic [3:0]  io_b;
        logic [3:0]  io_a;
        logic        en_u;
        logic        en_v;
        logic        en_a;
        logic        f_u;
        logic        f_v;
        logic        f_a;
        logic [15:0] cnt;
        logic [15:0] gra;
        logic [5:0]  div;
        logic [15:0] rdata;
        tcs_irq_s    irq;
        logic        lock_clr;
    } tcs_state_s;

endpackage

//--- rtl/tcs_pin_sync.sv
`timescale 1ns/1ps

module tcs_pin_sync (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      rise
);
    // ----------------------------------------------------------------
    // two-stage synchroniser, edge taken from the second and third stage
    // ----------------------------------------------------------------
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            rise   <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
            rise   <= sync_r & ~last_r;
        end
    end
endmodule // tcs_pin_sync

//--- rtl/tcs_top.sv
`timescale 1ns/1ps


module tcs_top (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire tcs_pkg::tcs_bus_req_s bus_req,
    output logic [15:0]                rdata,
    input  wire logic                  capture_input_pin_a,
    input  wire logic                  lockstep_clear_in,
    output logic                       lockstep_clear_out,
    output logic                       counter_run_ch1,
    output logic                       counter_run_ch2,
    output logic                       underflow_irq_request,
    output logic                       overflow_irq_request,
    output logic                       match_capture_irq_request_a,
    output logic                       irq
);
    import tcs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tcs_state_s state_r;
    tcs_state_s state_nxt;
    logic       pin_rise;

    // ----------------------------------------------------------------
    // capture pin
    // ----------------------------------------------------------------
    tcs_pin_sync u_pin_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pin     (capture_input_pin_a),
        .rise    (pin_rise)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [5:0] psc_mask(input logic [2:0] sel);
        logic [5:0] m;
        m = PSC_MASK_64;
        unique case (sel)
            3'h0:    m = PSC_MASK_1;
            3'h1:    m = PSC_MASK_4;
            3'h2:    m = PSC_MASK_16;
            default: m = PSC_MASK_64;
        endcase
        return m;
    endfunction

    function automatic logic hit(input tcs_bus_req_s r, input logic [23:0] ofs);
        return r.addr == ofs;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic        tick;
    logic        capt_mode;
    logic        capture;
    logic        match;
    logic        set_u;
    logic        set_v;
    logic        set_a;
    logic        clr_u;
    logic        clr_v;
    logic        clr_a;
    logic        own_clear;
    logic [15:0] cnt_step;
    logic [7:0]  wbyte;

    always_comb begin
        state_nxt = state_r;
        wbyte     = bus_req.wdata[7:0];
        set_u     = 1'b0;
        set_v     = 1'b0;
        set_a     = 1'b0;
        own_clear = 1'b0;
        cnt_step  = state_r.cnt;

        // prescaler only runs with the channel, so a stop freezes phase
        tick = 1'b0;
        if (state_r.run[0]) begin
            if ((state_r.div & psc_mask(state_r.tpsc)) == psc_mask(state_r.tpsc)) begin
                tick          = 1'b1;
                state_nxt.div = '0;
            end else begin
                state_nxt.div = state_r.div + 6'h01;
            end
        end

        capt_mode = state_r.io_a == IOA_CAPT_RISE;
        capture   = capt_mode && pin_rise;
        match     = tick && !capt_mode && (state_r.cnt == state_r.gra);

        // counting, direction from the mode bit
        if (tick) begin
            if (state_r.down) begin
                cnt_step = state_r.cnt - 16'h0001;
                if (state_r.cnt == 16'h0000) begin
                    set_u = 1'b1;
                end
            end else begin
                cnt_step = state_r.cnt + 16'h0001;
                if (state_r.cnt == 16'hFFFF) begin
                    set_v = 1'b1;
                end
            end
        end
        state_nxt.cnt = cnt_step;

        if (match) begin
            set_a = 1'b1;
            if (state_r.cclr == CCLR_ON_A) begin
                own_clear = 1'b1;
            end
        end

        // capture still lands while stopped, only the clear is held off
        if (capture) begin
            state_nxt.gra = state_r.cnt;
            set_a         = 1'b1;
            if (state_r.cclr == CCLR_ON_A && state_r.run[0]) begin
                own_clear = 1'b1;
            end
        end

        if (own_clear) begin
            state_nxt.cnt = RST_CNT;
        end

        // lockstep partner clears join only when this channel is in lockstep
        if (state_r.lock[0] && state_r.run[0] && lockstep_clear_in) begin
            state_nxt.cnt = RST_CNT;
        end
        state_nxt.lock_clr = state_r.lock[0] && own_clear;

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        clr_u = 1'b0;
        clr_v = 1'b0;
        clr_a = 1'b0;
        if (bus_req.wr) begin
            if (hit(bus_req, OFS_RUN)) begin
                // reserved upper bits are not stored
                state_nxt.run = wbyte[CH_COUNT-1:0];
            end
            if (hit(bus_req, OFS_LOCK)) begin
                state_nxt.lock = wbyte[CH_COUNT-1:0];
            end
            if (hit(bus_req, OFS_CTRL)) begin
                state_nxt.cclr = wbyte[CCLR_LSB +: 3];
                state_nxt.ckeg = wbyte[CKEG_LSB +: 2];
                state_nxt.tpsc = wbyte[TPSC_LSB +: 3];
            end
            if (hit(bus_req, OFS_MODE)) begin
                state_nxt.down = wbyte[BIT_DOWN];
            end
            if (hit(bus_req, OFS_IOCTL)) begin
                state_nxt.io_a = wbyte[IOA_LSB +: 4];
                state_nxt.io_b = wbyte[IOB_LSB +: 4];
            end
            if (hit(bus_req, OFS_IRQEN)) begin
                state_nxt.en_u = wbyte[BIT_UNF];
                state_nxt.en_v = wbyte[BIT_OVF];
                state_nxt.en_a = wbyte[BIT_MCA];
            end
            if (hit(bus_req, OFS_STAT)) begin
                clr_u = wbyte[BIT_UNF];
                clr_v = wbyte[BIT_OVF];
                clr_a = wbyte[BIT_MCA];
            end
            // software load beats the count in the same cycle
            if (hit(bus_req, OFS_CNT)) begin
                state_nxt.cnt = bus_req.wdata;
            end
            // a capture in the same cycle keeps the captured value
            if (hit(bus_req, OFS_GRA) && !capture) begin
                state_nxt.gra = bus_req.wdata;
            end
        end

        // set beats write-one clear so no event is lost
        state_nxt.f_u = (state_r.f_u & ~clr_u) | set_u;
        state_nxt.f_v = (state_r.f_v & ~clr_v) | set_v;
        state_nxt.f_a = (state_r.f_a & ~clr_a) | set_a;

        // requests registered from the next flags and enables
        state_nxt.irq.unf = state_nxt.f_u & state_nxt.en_u;
        state_nxt.irq.ovf = state_nxt.f_v & state_nxt.en_v;
        state_nxt.irq.mca = state_nxt.f_a & state_nxt.en_a;
        state_nxt.irq.any = state_nxt.irq.unf | state_nxt.irq.ovf | state_nxt.irq.mca;

        // ------------------------------------------------------------
        // register reads, data valid one cycle only
        // ------------------------------------------------------------
        state_nxt.rdata = RD_NONE;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_RUN:   state_nxt.rdata = {13'h0000, state_r.run};
                OFS_LOCK:  state_nxt.rdata = {13'h0000, state_r.lock};
                OFS_CTRL:  state_nxt.rdata = {8'h00, state_r.cclr, state_r.ckeg,
                                              state_r.tpsc};
                OFS_MODE:  state_nxt.rdata = {15'h0000, state_r.down};
                OFS_IOCTL: state_nxt.rdata = {8'h00, state_r.io_b, state_r.io_a};
                OFS_IRQEN: state_nxt.rdata = {10'h000, state_r.en_u, state_r.en_v,
                                              3'h0, state_r.en_a};
                OFS_STAT:  state_nxt.rdata = {8'h00, ~state_r.down, 1'b0,
                                              state_r.f_u, state_r.f_v,
                                              3'h0, state_r.f_a};
                OFS_CNT:   state_nxt.rdata = state_r.cnt;
                OFS_GRA:   state_nxt.rdata = state_r.gra;
                default:   state_nxt.rdata = RD_NONE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r          <= '0;
            state_r.cnt      <= RST_CNT;
            state_r.gra      <= RST_GRA;
            state_r.rdata    <= RD_NONE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign rdata                       = state_r.rdata;
    assign lockstep_clear_out          = state_r.lock_clr;
    assign counter_run_ch1             = state_r.run[1];
    assign counter_run_ch2             = state_r.run[2];
    assign underflow_irq_request       = state_r.irq.unf;
    assign overflow_irq_request        = state_r.irq.ovf;
    assign match_capture_irq_request_a = state_r.irq.mca;
    assign irq                         = state_r.irq.any;

endmodule // tcs_top

//--- tb/tcs_pin_drv.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// far-side edge source for the capture pin
// ------------------------------------------------------------
module tcs_pin_drv (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic fire,
    output logic      pin
);
    logic [1:0] hold_r;

    // high for three cycles so the two-stage sync always sees it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin    <= 1'b0;
            hold_r <= 2'h0;
        end else if (fire && hold_r == 2'h0) begin
            pin    <= 1'b1;
            hold_r <= 2'h3;
        end else if (hold_r != 2'h0) begin
            hold_r <= hold_r - 2'h1;
            if (hold_r == 2'h1) begin
                pin <= 1'b0;
            end
        end
    end
endmodule // tcs_pin_drv

//--- tb/tcs_top_checker.sv
`timescale 1ns/1ps

module tcs_top_checker (
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    input wire tcs_pkg::tcs_bus_req_s bus_req,
    input wire logic [15:0]           rdata,
    input wire logic                  capture_input_pin_a,
    input wire logic                  lockstep_clear_in,
    input wire logic                  lockstep_clear_out,
    input wire logic                  counter_run_ch1,
    input wire logic                  counter_run_ch2,
    input wire logic                  underflow_irq_request,
    input wire logic                  overflow_irq_request,
    input wire logic                  match_capture_irq_request_a,
    input wire logic                  irq
);
    import tcs_pkg::*;

    // ------------------------------------------------------------
    // bus and request relations
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_rdata_idle: assert property (
        !bus_req.rd |=> rdata == RD_NONE) else $error("read data outside read slot");
    a_run_resv: assert property (
        bus_req.rd && bus_req.addr == OFS_RUN |=> rdata[15:3] == 13'h0000)
        else $error("run register spare bits nonzero");
    a_lock_resv: assert property (
        bus_req.rd && bus_req.addr == OFS_LOCK |=> rdata[15:3] == 13'h0000)
        else $error("lockstep register spare bits nonzero");
    a_run_write: assert property (
        bus_req.wr && bus_req.addr == OFS_RUN |=>
        counter_run_ch1 == $past(bus_req.wdata[1]) && counter_run_ch2 == $past(bus_req.wdata[2]))
        else $error("run outputs do not follow write");
    a_run_hold: assert property (
        !(bus_req.wr && bus_req.addr == OFS_RUN) |=>
        $stable(counter_run_ch1) && $stable(counter_run_ch2)) else $error("run outputs moved");
    a_unf_sticky: assert property (
        underflow_irq_request && !bus_req.wr |=> underflow_irq_request)
        else $error("underflow request dropped");
    a_ovf_sticky: assert property (
        overflow_irq_request ##0 !bus_req.wr [*2] |=> overflow_irq_request)
        else $error("overflow request dropped");
    a_mca_sticky: assert property (
        $rose(match_capture_irq_request_a) ##0 !bus_req.wr |=> match_capture_irq_request_a)
        else $error("match request dropped");
    a_irq_or: assert property (
        irq == (underflow_irq_request || overflow_irq_request || match_capture_irq_request_a))
        else $error("irq not the or of requests");
    a_stat_flags: assert property (
        bus_req.rd && bus_req.addr == OFS_STAT |=> (rdata & 16'hFF4E) == 16'h0000
        && rdata[5] >= $past(underflow_irq_request) && rdata[4] >= $past(overflow_irq_request)
        && rdata[0] >= $past(match_capture_irq_request_a)) else $error("status read wrong");
endmodule // tcs_top_checker

bind tcs_top tcs_top_checker u_tcs_top_checker (
    .mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
    .capture_input_pin_a(capture_input_pin_a), .lockstep_clear_in(lockstep_clear_in),
    .lockstep_clear_out(lockstep_clear_out), .counter_run_ch1(counter_run_ch1),
    .counter_run_ch2(counter_run_ch2), .underflow_irq_request(underflow_irq_request),
    .overflow_irq_request(overflow_irq_request),
    .match_capture_irq_request_a(match_capture_irq_request_a), .irq(irq));

//--- tb/tcs_top_test.sv
`timescale 1ns/1ps

module tcs_top_test;
    import tcs_pkg::*;

    logic         mclk = 1'b0;
    logic         sys_rst;
    logic         fire;
    logic         pin;
    logic         lk_in;
    logic         lk_out;
    logic         run1;
    logic         run2;
    logic         unf_q;
    logic         ovf_q;
    logic         mca_q;
    logic         irq;
    tcs_bus_req_s req;
    logic [15:0]  rdata;
    logic [15:0]  r;
    logic [15:0]  v;
    logic [31:0]  seed;
    int           num_errors = 0;
    int           total_checks = 0;
    int           lk_seen = 0;
    int           lk_base;

    always #25 mclk = ~mclk;

    // lockstep clear pulses last one cycle, so count them as they come
    always @(posedge mclk) begin
        if (lk_out === 1'b1) begin
            lk_seen <= lk_seen + 1;
        end
    end

    tcs_top u_tcs_top (.mclk(mclk), .sys_rst(sys_rst), .bus_req(req), .rdata(rdata),
        .capture_input_pin_a(pin), .lockstep_clear_in(lk_in), .lockstep_clear_out(lk_out),
        .counter_run_ch1(run1), .counter_run_ch2(run2), .underflow_irq_request(unf_q),
        .overflow_irq_request(ovf_q), .match_capture_irq_request_a(mca_q), .irq(irq));
    tcs_pin_drv u_tcs_pin_drv (.mclk(mclk), .sys_rst(sys_rst), .fire(fire), .pin(pin));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    function automatic logic [15:0] st(input logic d, u, o, a);
        return {8'h00, d, 1'b0, u, o, 3'h0, a};
    endfunction

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [23:0] a);
        @(posedge mclk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        @(negedge mclk);
        r = rdata;
    endtask

    task automatic q(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic pulse();
        @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #250000;
        num_errors++;
        stop_test();
    end

    initial begin
        sys_rst = 1'b1;
        req = '0;
        fire = 1'b0;
        lk_in = 1'b0;
        seed = 32'h00000034;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(OFS_STAT); chk("stat", r, st(1, 0, 0, 0));
        rd(OFS_CNT); chk("cnt", r, RST_CNT);
        rd(OFS_GRA); chk("gra", r, RST_GRA);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            wr(OFS_CNT, v); rd(OFS_CNT); chk("cnt", r, v);
            wr(OFS_GRA, ~v); rd(OFS_GRA); chk("gra", r, ~v);
            wr(OFS_RUN, v & 16'h0006); rd(OFS_RUN); chk("run", r, v & 16'h0006);
            chk("run_out", {14'h0000, run2, run1}, {14'h0000, v[2:1]});
            wr(OFS_LOCK, v); rd(OFS_LOCK); chk("lock", r, v & 16'h0007);
            rd({8'h00, v}); chk("unmapped", r, RD_NONE);
        end
        wr(OFS_LOCK, 16'h0000);
        wr(OFS_CNT, 16'h4321); q(6); rd(OFS_CNT); chk("cnt_hold", r, 16'h4321);
        $display("test registers done");
        wr(OFS_GRA, 16'h1234); wr(OFS_CNT, 16'hFFFE); wr(OFS_RUN, 16'h0001);
        q(4); wr(OFS_RUN, 16'h0000);
        rd(OFS_STAT); chk("stat", r & 16'h00B1, st(1, 0, 1, 0));
        chk("ovf_req", {15'h0000, ovf_q}, 16'h0000);
        wr(OFS_IRQEN, 16'h0010); q(10);
        chk("ovf_req", {15'h0000, ovf_q}, 16'h0001);
        chk("irq", {15'h0000, irq}, 16'h0001);
        wr(OFS_STAT, 16'h0010); q(2);
        chk("ovf_req", {15'h0000, ovf_q}, 16'h0000);
        $display("test overflow done");
        wr(OFS_MODE, 16'h0001); wr(OFS_CNT, 16'h0001); wr(OFS_RUN, 16'h0001);
        q(4); wr(OFS_RUN, 16'h0000);
        rd(OFS_STAT); chk("stat", r & 16'h00B1, st(0, 1, 0, 0));
        chk("unf_req", {15'h0000, unf_q}, 16'h0000);
        wr(OFS_IRQEN, 16'h0020); q(2);
        chk("unf_req", {15'h0000, unf_q}, 16'h0001);
        wr(OFS_STAT, 16'h0020); wr(OFS_MODE, 16'h0000); q(2);
        chk("irq", {15'h0000, irq}, 16'h0000);
        $display("test underflow done");
        wr(OFS_CTRL, 16'h0020); wr(OFS_GRA, 16'h0005); wr(OFS_CNT, 16'h0000);
        wr(OFS_IRQEN, 16'h0001); wr(OFS_RUN, 16'h0001); q(20); wr(OFS_RUN, 16'h0000);
        rd(OFS_CNT); chk("cnt_le_a", {15'h0000, r <= 16'h0005}, 16'h0001);
        rd(OFS_STAT); chk("stat", r & 16'h00B1, st(1, 0, 0, 1));
        chk("mca_req", {15'h0000, mca_q}, 16'h0001);
        wr(OFS_IRQEN, 16'h0000); q(2);
        chk("mca_req", {15'h0000, mca_q}, 16'h0000);
        $display("test match done");
        v = rnd();
        wr(OFS_IOCTL, 16'h0008); wr(OFS_CNT, v); wr(OFS_STAT, 16'h0031);
        pulse(); q(8);
        rd(OFS_GRA); chk("gra_capt", r, v);
        rd(OFS_CNT); chk("cnt_stop", r, v);
        rd(OFS_STAT); chk("stat", r & 16'h00B1, st(1, 0, 0, 1));
        wr(OFS_CTRL, 16'h0023); wr(OFS_CNT, 16'h0100); wr(OFS_RUN, 16'h0001);
        pulse(); q(8); wr(OFS_RUN, 16'h0000);
        rd(OFS_GRA); chk("gra_run", {15'h0000, r >= 16'h0100 && r <= 16'h0102}, 16'h0001);
        rd(OFS_CNT); chk("cnt_clr", {15'h0000, r < 16'h0003}, 16'h0001);
        $display("test capture done");
        wr(OFS_CTRL, 16'h0020); wr(OFS_IOCTL, 16'h0000); wr(OFS_GRA, 16'h0003);
        wr(OFS_CNT, 16'h0000); wr(OFS_LOCK, 16'h0001);
        lk_base = lk_seen;
        wr(OFS_RUN, 16'h0001); q(12);
        chk("lock_out", {15'h0000, lk_seen > lk_base}, 16'h0001);
        wr(OFS_CTRL, 16'h0000); wr(OFS_CNT, 16'h8000);
        @(posedge mclk);
        lk_in <= 1'b1;
        @(posedge mclk);
        lk_in <= 1'b0;
        wr(OFS_RUN, 16'h0000);
        rd(OFS_CNT); chk("lock_clr", {15'h0000, r < 16'h0010}, 16'h0001);
        wr(OFS_LOCK, 16'h0000);
        $display("test lockstep done");
        stop_test();
    end
endmodule // tcs_top_test
